// File: eanc_defines.vh
// Purpose: constants for the auto-negotiation and duplex control block
// Assumes: 100 MHz clk, 10 ns period
// Notes: definitions only
`ifndef EANC_DEFINES_VH
`define EANC_DEFINES_VH
// link code word fields
`define EANC_SEL_LSB 0
`define EANC_SEL_MSB 4
`define EANC_SEL_8023 5'h01
`define EANC_ABL_LSB 5
`define EANC_ABL_MSB 8
`define EANC_ABL_10HD 5
`define EANC_ABL_10FD 6
`define EANC_ABL_100HD 7
`define EANC_ABL_100FD 8
`define EANC_ACK_BIT 14
`define EANC_LCW_BITS 16
// burst shape
`define EANC_BURST_SLOTS 6'h21
`define EANC_BURST_DATA 5'h10
// break link timer
`define EANC_BREAK_MS 1250
`define EANC_CLK_KHZ 100000
`define EANC_BREAK_CYC (`EANC_BREAK_MS * `EANC_CLK_KHZ)
// words that must match in a row before ack / completion
`define EANC_MATCH_CNT 3'h3
`define EANC_ACK_CNT 3'h3
// resolved mode codes: {speed100, full}
`define EANC_M10HD 2'h0
`define EANC_M10FD 2'h1
`define EANC_M100HD 2'h2
`define EANC_M100FD 2'h3
// strap codes: all abilities, negotiation off
`define EANC_STRAP_ALL 3'h7
`define EANC_STRAP_NOAN 3'h0
`endif

// File: eanc_flp_rx.v
// Purpose: collect a received fast link pulse burst into a code word
// Assumes: slot strobe and pulse flag from the analog front end, synced
// Notes: odd slots must carry a pulse or the burst is thrown away
`timescale 1ns/1ns
`include "eanc_defines.vh"
module eanc_flp_rx (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire burst_start,
  input wire slot_strobe,
  input wire slot_pulse,
  output reg [15:0] word,
  output reg word_valid,
  output reg burst_bad
);
  reg [5:0] slot; // current pulse position, 1-based
  reg [15:0] shift; // data bits, first bit received lands in bit 0
  reg active; // inside a burst
  // slot walker: clock slots odd, data slots even
  always @(posedge clk) begin
    if (reset) begin
      slot <= 6'h00;
      shift <= 16'h0000;
      active <= 1'b0;
      word <= 16'h0000;
      word_valid <= 1'b0;
      burst_bad <= 1'b0;
    end else if (ce) begin
      word_valid <= 1'b0;
      burst_bad <= 1'b0;
      if (burst_start) begin
        active <= 1'b1;
        slot <= 6'h01;
        shift <= 16'h0000;
      end else if (active && slot_strobe) begin
        if (slot[0] && !slot_pulse) begin
          // missing clock pulse: burst incomplete
          active <= 1'b0;
          burst_bad <= 1'b1;
        end else begin
          if (!slot[0]) begin
            shift <= {slot_pulse, shift[15:1]}; // pulse = one
          end
          if (slot == `EANC_BURST_SLOTS) begin
            active <= 1'b0;
            word <= shift;
            word_valid <= 1'b1;
          end
          slot <= slot + 6'h01;
        end
      end
    end
  end
endmodule // eanc_flp_rx

// File: eanc_lp_model.sv
// Purpose: remote link partner sending fast link pulse bursts
// Assumes: a pulse position is marked by the strobe's rising edge
// Notes: free-running timing, unrelated in phase to clk
`timescale 1ns/1ns
module eanc_lp_model (
  output reg burst_start,
  output reg slot_strobe,
  output reg slot_pulse
);
  integer s; // slot index, 1 to 33
  // lines idle low between bursts, except slot_pulse after a cut burst
  initial begin
    burst_start = 1'b0;
    slot_strobe = 1'b0;
    slot_pulse = 1'b0;
  end
  // one burst: odd slots always pulse, even slots carry the word
  task send_word(input [15:0] w);
    begin
      burst_start = 1'b1;
      #73 burst_start = 1'b0;
      for (s = 1; s <= 33; s = s + 1) begin
        slot_pulse = (s % 2) ? 1'b1 : w[s/2-1];
        #37 slot_strobe = 1'b1;
        #83 slot_strobe = 1'b0;
        // hold time over: never leave the old level showing
        #11 slot_pulse = ~slot_pulse;
        #47;
      end
      #997;
    end
  endtask
  // a burst cut short: the second clock pulse, in slot 3, never comes
  task send_cut;
    begin
      burst_start = 1'b1;
      #73 burst_start = 1'b0;
      for (s = 1; s <= 3; s = s + 1) begin
        slot_pulse = (s != 3);
        #37 slot_strobe = 1'b1;
        #83 slot_strobe = 1'b0;
        #11 slot_pulse = ~slot_pulse;
        #47;
      end
      #997;
    end
  endtask
endmodule // eanc_lp_model

// File: eanc_props.sv
// Purpose: port-level checker for the auto-negotiation control block
// Assumes: one clock domain, sync active high reset
// Notes: attached to eanc_top by the bind at the foot of this file
`timescale 1ns/1ns
`include "eanc_defines.vh"
module eanc_props #(
  parameter BREAK_CYC = 20
) (
  input wire clk,
  input wire reset,
  input wire an_enable,
  input wire restart_set,
  input wire restart_pending,
  input wire force_speed100,
  input wire force_full,
  input wire adv_write,
  input wire [3:0] adv_wdata,
  input wire [15:0] adv_reg,
  input wire [15:0] tx_word,
  input wire tx_burst_en,
  input wire link_halt,
  input wire tx_active,
  input wire rx_active,
  input wire crs,
  input wire col,
  input wire speed100,
  input wire full_duplex,
  input wire par_det_fault
);
  // every property shares the one clock and its reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_adv_write_lands: assert property (adv_write |=>
    adv_reg[8:5] == $past(adv_wdata)) else $error("adv write lost");
  a_selector_sent: assert property (tx_burst_en |->
    tx_word[4:0] == `EANC_SEL_8023) else $error("bad selector");
  a_abil_sent: assert property (tx_burst_en |->
    tx_word[8:5] == $past(adv_reg[8:5])) else $error("abilities differ");
  a_restart_taken: assert property (restart_set |=>
    restart_pending) else $error("restart not taken");
  a_restart_clears: assert property ($rose(restart_pending) &&
    !restart_set |-> ##[1:3] (link_halt && !restart_pending))
    else $error("restart not self cleared");
  a_full_no_col: assert property (full_duplex |=> !col)
    else $error("collision in full duplex");
  a_full_crs_rx: assert property (full_duplex |=>
    crs == $past(rx_active)) else $error("crs full wrong");
  a_half_crs_both: assert property (!full_duplex |=>
    crs == ($past(tx_active) || $past(rx_active)))
    else $error("crs half wrong");
  a_half_col_seen: assert property (!full_duplex && tx_active &&
    rx_active |=> col) else $error("collision missed");
  a_forced_mode: assert property ((!an_enable && $stable(force_speed100)
    && $stable(force_full))[*4] |-> speed100 == force_speed100 &&
    full_duplex == force_full) else $error("forced mode wrong");
  a_fault_sticky: assert property ($past(par_det_fault) |->
    par_det_fault) else $error("fault bit dropped");
endmodule // eanc_props

bind eanc_top eanc_props #(.BREAK_CYC(BREAK_CYC)) u_props (.clk, .reset,
  .an_enable, .restart_set, .restart_pending, .force_speed100,
  .force_full, .adv_write, .adv_wdata, .adv_reg, .tx_word, .tx_burst_en,
  .link_halt, .tx_active, .rx_active, .crs, .col, .speed100,
  .full_duplex, .par_det_fault);

// File: eanc_sync3.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from outside the clk domain
// Notes: output changes when stages two and three agree
`timescale 1ns/1ns
module eanc_sync3 #(
  parameter W = 1
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1; // first stage, read only by s2
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;
  // shift and filter; per-bit agreement
  always @(posedge clk) begin
    if (reset) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule // eanc_sync3

// File: eanc_tb.sv
// Purpose: self-checking bench for the auto-negotiation control block
// Assumes: 100 MHz clk, short break timer for simulation
// Notes: stimulus at rising edges, outputs sampled 1 ns later
`timescale 1ns/1ns
module tb_top;
  localparam BRK = 20; // short break timer keeps the run brief
  reg clk, reset, an_enable, restart_set, force_speed100, force_full;
  reg adv_write, det_mlt3, det_nlp, sig_detect, link_up;
  reg tx_active, rx_active, soft_reset, power_down_reset;
  reg [3:0] adv_wdata;
  reg [2:0] mode_strap;
  wire rx_burst_start, rx_slot_strobe, rx_slot_pulse;
  wire restart_pending, partner_an_able, par_det_fault, an_complete;
  wire speed100, full_duplex, tx_burst_en, link_halt, crs, col;
  wire [15:0] adv_reg, partner_reg, tx_word;
  integer err_total = 0; // mismatches seen
  integer cmp_count = 0; // comparisons made

  eanc_top #(.BREAK_CYC(BRK)) dut (.clk(clk), .reset(reset), .ce(1'b1),
    .an_enable(an_enable), .restart_set(restart_set),
    .restart_pending(restart_pending), .soft_reset(soft_reset),
    .power_down_reset(power_down_reset), .force_speed100(force_speed100),
    .force_full(force_full), .adv_write(adv_write),
    .adv_wdata(adv_wdata), .adv_reg(adv_reg), .partner_reg(partner_reg),
    .partner_an_able(partner_an_able), .par_det_fault(par_det_fault),
    .an_complete(an_complete), .speed100(speed100),
    .full_duplex(full_duplex), .mode_strap(mode_strap),
    .rx_burst_start(rx_burst_start), .rx_slot_strobe(rx_slot_strobe),
    .rx_slot_pulse(rx_slot_pulse), .det_mlt3(det_mlt3),
    .det_nlp(det_nlp), .sig_detect(sig_detect), .link_up(link_up),
    .tx_word(tx_word), .tx_burst_en(tx_burst_en), .link_halt(link_halt),
    .tx_active(tx_active), .rx_active(rx_active), .crs(crs), .col(col));
  eanc_lp_model lp (.burst_start(rx_burst_start),
    .slot_strobe(rx_slot_strobe), .slot_pulse(rx_slot_pulse));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // compare one value, count it, report a mismatch
  task chk(input string nm, input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // bounded wait: 0 burst enable, 1 complete, 2 halt, 3 fault
  task wait_hi(input integer k);
    integer n;
    begin
      n = 0;
      while (n < 4000 && ((k == 0) ? tx_burst_en : (k == 1) ? an_complete
        : (k == 2) ? link_halt : par_det_fault) !== 1'b1) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk("wait flag", n < 4000, 1);
    end
  endtask
  // restart request, break phase timed, back to sending bursts
  task restart;
    integer n;
    begin
      @(posedge clk);
      restart_set <= 1'b1;
      @(posedge clk);
      restart_set <= 1'b0;
      #1;
      chk("restart bit", restart_pending, 1);
      wait_hi(2);
      chk("restart cleared", restart_pending, 0);
      chk("no bursts in break", tx_burst_en, 0);
      n = 0;
      while (link_halt === 1'b1 && n < 4000) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk("break length", n >= BRK - 2 && n < BRK + 8, 1);
      wait_hi(0);
    end
  endtask
  // write abilities, check no restart, negotiate with the partner
  task t_neg(input [3:0] adv, input [3:0] pab, input es, input ef);
    reg [15:0] pw;
    begin
      pw = {7'h00, pab, 5'h01};
      @(posedge clk);
      adv_write <= 1'b1;
      adv_wdata <= adv;
      @(posedge clk);
      adv_write <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("adv reg", adv_reg[8:5], adv);
      chk("no self restart", link_halt, 0);
      restart;
      chk("sent abilities", tx_word[8:0], {adv, 5'h01});
      repeat (3) lp.send_word(pw);
      chk("ack sent", tx_word[14], 1);
      repeat (3) lp.send_word(pw | 16'h4000);
      wait_hi(1);
      chk("speed", speed100, es);
      chk("duplex", full_duplex, ef);
      chk("partner word", partner_reg[8:0], pw[8:0]);
      chk("partner able", partner_an_able, 1);
    end
  endtask
  // losing the signal or the link, or a soft or power-down reset, must start a new session
  task t_drop(input integer k);
    begin
      @(posedge clk);
      if (k == 0) sig_detect <= 1'b0;
      else if (k == 1) link_up <= 1'b0;
      else if (k == 2) soft_reset <= 1'b1;
      else power_down_reset <= 1'b1;
      wait_hi(2);
      chk("session restarted", an_complete, 0);
      @(posedge clk);
      sig_detect <= 1'b1;
      link_up <= 1'b1;
      soft_reset <= 1'b0;
      power_down_reset <= 1'b0;
      wait_hi(0);
    end
  endtask
  // partner without negotiation, then a detection fault
  task t_pardet;
    begin
      restart;
      @(posedge clk);
      det_nlp <= 1'b1;
      wait_hi(1);
      @(posedge clk);
      #1;
      chk("pd speed", speed100, 0);
      chk("pd duplex", full_duplex, 0);
      chk("pd able bit", partner_an_able, 0);
      chk("pd partner", partner_reg[8:5], 4'h1);
      @(posedge clk);
      det_nlp <= 1'b0;
      restart;
      @(posedge clk);
      det_mlt3 <= 1'b1;
      det_nlp <= 1'b1;
      wait_hi(3);
      chk("pd fault", par_det_fault, 1);
      @(posedge clk);
      det_mlt3 <= 1'b0;
      det_nlp <= 1'b0;
    end
  endtask
  // forced half then full duplex, carrier and collision behaviour
  task t_forced;
    begin
      @(posedge clk);
      an_enable <= 1'b0;
      force_speed100 <= 1'b1;
      tx_active <= 1'b1;
      rx_active <= 1'b1;
      repeat (20) @(posedge clk);
      #1;
      chk("forced speed", speed100, 1);
      chk("forced half", full_duplex, 0);
      chk("half col", col, 1);
      chk("half crs", crs, 1);
      @(posedge clk);
      force_full <= 1'b1;
      rx_active <= 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk("forced full", full_duplex, 1);
      chk("full crs", crs, 0);
      chk("full col", col, 0);
    end
  endtask
  // partner word changes or a burst is cut while acknowledging
  task t_abort(input integer k);
    reg [15:0] pw;
    begin
      pw = {7'h00, 4'hf, 5'h01};
      restart;
      repeat (3) lp.send_word(pw);
      chk("ack before abort", tx_word[14], 1);
      if (k == 0) lp.send_cut;
      else lp.send_word(pw ^ 16'h0100);
      // only a break leads from ack back to plain words
      chk("ack dropped", tx_word[14], 0);
      chk("abort no complete", an_complete, 0);
    end
  endtask
  // second reset with the straps that turn negotiation off
  task t_strap_off;
    begin
      @(posedge clk);
      reset <= 1'b1;
      mode_strap <= 3'h0;
      an_enable <= 1'b1;
      force_full <= 1'b0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("strap off adv", adv_reg, 16'h0021);
      chk("strap off no an", link_halt, 0);
      chk("strap off forced", full_duplex, 0);
    end
  endtask
  // verdict and end of run
  task stop_test;
    begin
      if (err_total == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // hang guard: the tests need about 22000 cycles
  initial begin
    #900000;
    err_total = err_total + 1;
    stop_test;
  end
  // main sequence
  initial begin
    reset = 1'b1;
    an_enable = 1'b1;
    {restart_set, force_speed100, force_full, adv_write} = 4'h0;
    {soft_reset, power_down_reset} = 2'h0;
    {det_mlt3, det_nlp, tx_active, rx_active} = 4'h0;
    sig_detect = 1'b1;
    link_up = 1'b1;
    adv_wdata = 4'h0;
    mode_strap = 3'h7;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("strap adv", adv_reg, 16'h01e1);
    chk("reset starts session", link_halt, 1);
    wait_hi(0);
    t_neg(4'hf, 4'h9, 1'b1, 1'b1);
    t_drop(0);
    t_neg(4'h3, 4'hf, 1'b0, 1'b1);
    t_drop(1);
    t_neg(4'hf, 4'h6, 1'b1, 1'b0);
    t_drop(2);
    t_neg(4'h1, 4'hf, 1'b0, 1'b0);
    t_drop(3);
    t_abort(0);
    t_abort(1);
    t_pardet;
    t_forced;
    t_strap_off;
    stop_test;
  end
endmodule // tb_top

// File: eanc_top.v
// Purpose: auto-negotiation, parallel detect and duplex control
// Assumes: 100 MHz clk; pulse timing done by the analog front end
// Notes: transmitted burst shaping is left to the pulse driver
// Overview of operation
// [R1] start negotiation on resets, link down, restart
// [R2] burst: 17 clock pulses, 16 data slots
// [R3] selector field declares standard ethernet compliance
// [R4] sent abilities come from advertisement register
// [R5] pick best shared mode, 100 full first
// [R6] after match, send words with ack set
// [R7] changed partner word during ack restarts
// [R8] cut bursts clear the match count; during ack they restart negotiation
// [R9] straps latched at reset set advertisement
// [R10] software writes advertisement bits 8 to 5
// [R11] advertisement write alone does not restart
// [R12] negotiation off: use forced speed, duplex
// [R13] no pulses: detect speed, assume half duplex
// [R14] parallel detect clears partner able bit
// [R15] parallel detect fault sets fault bit
// [R16] partner register from words or detected speed
// [R17] signal loss restarts negotiation
// [R18] restart: halt, wait break timer, renegotiate
// [R19] report resolved speed and duplex
// [R20] half duplex: crs both ways, collisions flagged
// [R21] full duplex: crs receive only, no collision
// [R22] no handshake needed from the mac
// [R23] restart bit self clears once taken
`timescale 1ns/1ns
`include "eanc_defines.vh"
module eanc_top #(
  parameter BREAK_CYC = `EANC_BREAK_CYC
) (
  input wire clk,
  input wire reset,
  input wire ce,
  // management controls
  input wire an_enable,
  input wire restart_set,
  output reg restart_pending,
  input wire soft_reset,
  input wire power_down_reset,
  input wire force_speed100,
  input wire force_full,
  input wire adv_write,
  input wire [3:0] adv_wdata,
  output reg [15:0] adv_reg,
  output reg [15:0] partner_reg,
  output reg partner_an_able,
  output reg par_det_fault,
  output reg an_complete,
  output reg speed100,
  output reg full_duplex,
  // straps, sampled at reset release
  input wire [2:0] mode_strap,
  // front end, asynchronous
  input wire rx_burst_start,
  input wire rx_slot_strobe,
  input wire rx_slot_pulse,
  input wire det_mlt3,
  input wire det_nlp,
  input wire sig_detect,
  input wire link_up,
  // transmit burst request
  output reg [15:0] tx_word,
  output reg tx_burst_en,
  output reg link_halt,
  // mac activity
  input wire tx_active,
  input wire rx_active,
  output reg crs,
  output reg col
);
  // state codes, one-hot
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_BREAK = 6'h02;
  localparam [5:0] S_ABIL = 6'h04;
  localparam [5:0] S_ACK = 6'h08;
  localparam [5:0] S_DONE = 6'h10;
  localparam [5:0] S_FORCE = 6'h20;

  reg [5:0] state; // controller state
  reg [31:0] timer; // break link count
  reg [2:0] match_cnt; // consistent words seen
  reg [15:0] match_word; // word captured at match
  reg strap_done; // straps taken once after reset
  reg an_en_strap; // auto-negotiation enable from straps
  reg was_link; // previous link level for edge
  reg [1:0] mode; // resolved mode
  wire [15:0] rx_word;
  wire rx_valid;
  wire rx_bad;
  wire [6:0] fe; // synced front end levels
  wire fe_burst_start;
  wire fe_strobe;
  wire fe_pulse;
  wire fe_mlt3;
  wire fe_nlp;
  wire fe_sig;
  wire fe_link;
  wire an_on;
  reg [6:0] fe_prev; // previous synced strobes for edges
  wire start_ev;

  // front end crosses into clk; edges taken after the filter
  eanc_sync3 #(.W(7)) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .din({rx_burst_start, rx_slot_strobe, rx_slot_pulse, det_mlt3,
          det_nlp, sig_detect, link_up}),
    .dout(fe)
  );
  assign fe_burst_start = fe[6] & ~fe_prev[6];
  assign fe_strobe = fe[5] & ~fe_prev[5];
  assign fe_pulse = fe[4];
  assign fe_mlt3 = fe[3];
  assign fe_nlp = fe[2];
  assign fe_sig = fe[1];
  assign fe_link = fe[0];

  // burst collector
  eanc_flp_rx u_rx (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .burst_start(fe_burst_start),
    .slot_strobe(fe_strobe),
    .slot_pulse(fe_pulse),
    .word(rx_word),
    .word_valid(rx_valid),
    .burst_bad(rx_bad)
  );

  // best shared mode; bit 0 set when nothing shared
  function [2:0] eanc_resolve;
    input [15:0] a;
    input [15:0] b;
    begin
      if (a[`EANC_ABL_100FD] & b[`EANC_ABL_100FD])
        eanc_resolve = {`EANC_M100FD, 1'b0};
      else if (a[`EANC_ABL_100HD] & b[`EANC_ABL_100HD])
        eanc_resolve = {`EANC_M100HD, 1'b0};
      else if (a[`EANC_ABL_10FD] & b[`EANC_ABL_10FD])
        eanc_resolve = {`EANC_M10FD, 1'b0};
      else if (a[`EANC_ABL_10HD] & b[`EANC_ABL_10HD])
        eanc_resolve = {`EANC_M10HD, 1'b0};
      else
        eanc_resolve = {`EANC_M10HD, 1'b1};
    end
  endfunction

  // main content: everything but the ack bit
  function eanc_same;
    input [15:0] a;
    input [15:0] b;
    begin
      eanc_same = ((a ^ b) & ~(16'h0001 << `EANC_ACK_BIT)) == 16'h0000;
    end
  endfunction

  wire [2:0] res = eanc_resolve(adv_reg, rx_word);
  assign an_on = an_enable & an_en_strap;
  // fresh link-down edge or loss of signal restarts
  assign start_ev = soft_reset | power_down_reset | restart_pending |
                    (was_link & ~fe_link) | (~fe_sig & ~state[0]
                    & ~state[1] & ~state[5]); // R1 R17

  // strap capture and advertisement register
  always @(posedge clk) begin
    if (reset) begin
      strap_done <= 1'b0;
      an_en_strap <= 1'b1;
      adv_reg <= {11'h000, `EANC_SEL_8023};
    end else if (ce) begin
      if (!strap_done) begin
        strap_done <= 1'b1;
        // 3'b111 enables all; others advertise subsets; 3'b000 no an
        an_en_strap <= (mode_strap != `EANC_STRAP_NOAN); // R9
        adv_reg[`EANC_ABL_MSB:`EANC_ABL_LSB] <=
          (mode_strap == `EANC_STRAP_ALL) ? 4'hf :
          {mode_strap[1] & mode_strap[0], mode_strap[1],
           mode_strap[0], 1'b1}; // R9
      end else if (adv_write) begin
        // sent in tx_word two cycles after the write; does not start a new session
        adv_reg[`EANC_ABL_MSB:`EANC_ABL_LSB] <= adv_wdata; // R10 R11
      end
    end
  end

  // restart request flag; set beats self clear
  always @(posedge clk) begin
    if (reset) begin
      restart_pending <= 1'b0;
    end else if (ce) begin
      if (restart_set)
        restart_pending <= 1'b1;
      else if (state[1])
        restart_pending <= 1'b0; // R23
    end
  end

  // negotiation state machine; runs without mac involvement
  always @(posedge clk) begin // R22
    if (reset) begin
      state <= S_BREAK; // hardware reset starts a session
      timer <= 32'h0;
      match_cnt <= 3'h0;
      match_word <= 16'h0000;
      mode <= `EANC_M10HD;
      an_complete <= 1'b0;
      partner_reg <= 16'h0000;
      partner_an_able <= 1'b0;
      par_det_fault <= 1'b0;
      was_link <= 1'b0;
      fe_prev <= 7'h00;
    end else if (ce) begin
      fe_prev <= fe;
      was_link <= fe_link;
      if (!an_on) begin
        state <= S_FORCE;
        an_complete <= 1'b0;
        mode <= {force_speed100, force_full}; // R12
      end else if (start_ev && !state[1]) begin
        state <= S_BREAK; // R1 R17 R18
        timer <= 32'h0;
        an_complete <= 1'b0;
      end else begin
        case (state)
          S_FORCE: begin
            state <= S_BREAK; // enable raised again
            timer <= 32'h0;
          end
          S_IDLE: begin
            state <= S_BREAK;
            timer <= 32'h0;
          end
          S_BREAK: begin
            // quiet line so the partner drops too
            if (timer >= BREAK_CYC - 1) begin // R18
              state <= S_ABIL;
              match_cnt <= 3'h0;
            end else begin
              timer <= timer + 32'h1;
            end
          end
          S_ABIL: begin
            if (rx_bad) begin
              match_cnt <= 3'h0; // R8
            end else if (rx_valid) begin
              if (match_cnt != 3'h0 && !eanc_same(rx_word, match_word))
                match_cnt <= 3'h1;
              else if (match_cnt + 3'h1 >= `EANC_MATCH_CNT && !res[0]) begin
                state <= S_ACK; // R6
                match_cnt <= 3'h0;
              end else
                match_cnt <= match_cnt + 3'h1;
              match_word <= rx_word;
            end else if (fe_mlt3 ^ fe_nlp) begin
              // legacy partner: parallel detect, half duplex
              mode <= {fe_mlt3, 1'b0}; // R13
              partner_an_able <= 1'b0; // R14
              partner_reg <= {11'h000, `EANC_SEL_8023} |
                (fe_mlt3 ? (16'h0001 << `EANC_ABL_100HD)
                         : (16'h0001 << `EANC_ABL_10HD)); // R16
              an_complete <= 1'b1;
              state <= S_DONE;
            end else if (fe_mlt3 & fe_nlp) begin
              par_det_fault <= 1'b1; // R15
            end
          end
          S_ACK: begin
            if (rx_bad) begin
              state <= S_BREAK; // R8
              timer <= 32'h0;
            end else if (rx_valid) begin
              if (!eanc_same(rx_word, match_word)) begin
                state <= S_BREAK; // R7
                timer <= 32'h0;
              end else if (match_cnt + 3'h1 >= `EANC_ACK_CNT) begin
                mode <= res[2:1]; // R5
                partner_reg <= rx_word; // R16
                partner_an_able <= 1'b1;
                an_complete <= 1'b1;
                state <= S_DONE;
              end else begin
                match_cnt <= match_cnt + 3'h1;
              end
            end
          end
          S_DONE: begin
            state <= S_DONE; // left only by a start event or by negotiation being turned off
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // transmit word, burst enable, outputs of resolved mode
  always @(posedge clk) begin
    if (reset) begin
      tx_word <= 16'h0000;
      tx_burst_en <= 1'b0;
      link_halt <= 1'b1;
      speed100 <= 1'b0;
      full_duplex <= 1'b0;
    end else if (ce) begin
      tx_word <= adv_reg
        | (state[3] ? (16'h0001 << `EANC_ACK_BIT) : 16'h0000); // R3 R4 R6
      tx_burst_en <= state[2] | state[3]; // R2
      link_halt <= state[1]; // R18
      speed100 <= mode[1]; // R19
      full_duplex <= mode[0]; // R19
    end
  end

  // carrier sense and collision by duplex
  always @(posedge clk) begin
    if (reset) begin
      crs <= 1'b0;
      col <= 1'b0;
    end else if (ce) begin
      if (full_duplex) begin
        crs <= rx_active; // R21
        col <= 1'b0; // R21
      end else begin
        crs <= rx_active | tx_active; // R20
        col <= rx_active & tx_active; // R20
      end
    end
  end
endmodule // eanc_top
